/* core/pbc_checker.sv */
// Purpose: Pseudorandom sequence bit error checker with AHB-Lite registers.
// Assumes: Link clock, data, strobe and restart are asynchronous pins.
// Notes: Writes take no wait state; reads take one.
//
// Functional notes
// - Reference comes from a feedback shift register; each state has one successor.
// - Fill register from received bits, then self-feed and count every mismatch.
// - Bits shifted in during fill are never checked or counted.
// - About half the bits wrong after fill restarts the measurement automatically.
// - Sequence of degree n repeats every two to the n minus one bits.
// - Degrees 9, 11, 15, 16, 20, 21, 23; degree sixteen has two extra taps.
// - Restart disabled gives a continuous measurement needing only clock and data.
// - With strobe mode high, only bits taken while strobe is one count.
// - Integrating mode: restart rising edge latches partial result and stops.
// - Integrating mode: restart falling edge refills and starts the next sub-interval.
// - Sub-intervals accumulate; stop when either total reaches or exceeds its limit.
// - Total bits and errored bits are held in separate 32-bit counters.
// - Measurement ends when checked bits reach the bit limit.
// - Measurement ends when detected errors reach the error limit.
// - Both limits are live together; the ending cause is recorded.
// - Lock anywhere in the stream with no timing tie to the source.
// - Degrees fifteen and twenty-three invert the reference, apart from polarity.
// - Unqualified bits freeze the generator and checking; both resume afterwards.
// - Data are taken on the selected edge of the link clock.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_checker (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic        data_qualify_strobe,
  input  wire logic        restart_input
);
  pbc_gen_if gen_if ();

  logic [3:0]          pin_sync;
  logic                clk_q_r;
  logic                rst_q_r;
  logic [8:0]          ctrl_r;
  logic [31:0]         bit_lim_r;
  logic [31:0]         err_lim_r;
  logic [31:0]         bit_cnt_r;
  logic [31:0]         err_cnt_r;
  logic [31:0]         base_bits_r;
  logic [31:0]         base_errs_r;
  logic [31:0]         bit_cnt_nxt;
  logic [31:0]         err_cnt_nxt;
  logic [4:0]          fill_cnt_r;
  logic [6:0]          win_cnt_r;
  logic [6:0]          win_err_r;
  logic                sync_r;
  logic                by_bits_r;
  logic                by_errs_r;
  logic                wr_pend_r;
  logic                rd_pend_r;
  logic [7:0]          addr_r;
  pbc_pkg::pbc_state_e state_r;
  pbc_pkg::pbc_state_e state_nxt;

  wire s_clk  = pin_sync[3];
  wire s_data = pin_sync[2];
  wire s_strb = pin_sync[1];
  wire s_rst  = pin_sync[0];

  pbc_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   ({link_clk, link_data, data_qualify_strobe, restart_input}),
    .pin_sync (pin_sync)
  );

  pbc_lfsr #(
    .MAX_DEG (23)
  ) u_lfsr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .gen      (gen_if)
  );

  function automatic logic [4:0] pbc_degree(input pbc_pkg::pbc_poly_e p);
    case (p)
      pbc_pkg::poly9:  return 5'h09;
      pbc_pkg::poly11: return 5'h0b;
      pbc_pkg::poly15: return 5'h0f;
      pbc_pkg::poly16: return 5'h10;
      pbc_pkg::poly20: return 5'h14;
      pbc_pkg::poly21: return 5'h15;
      pbc_pkg::poly23: return 5'h17;
      default:         return 5'h09;
    endcase
  endfunction : pbc_degree

  // Bus decode: address phase capture and data phase write strobes.
  wire        addr_take = hsel && hready && htrans[1];
  wire        bus_wr    = wr_pend_r && hready;
  wire        ctrl_wr   = bus_wr && (addr_r == `PBC_OFF_CTRL);
  wire        start_wr  = ctrl_wr && hwdata[`PBC_CTRL_RUN];
  wire        stop_wr   = ctrl_wr && !hwdata[`PBC_CTRL_RUN];

  // Control fields.
  wire        ext_en    = ctrl_r[`PBC_CTRL_EXTRST];
  wire        pol_inv   = ctrl_r[`PBC_CTRL_POL];
  wire        edge_fall = ctrl_r[`PBC_CTRL_EDGE];
  wire [1:0]  qual_mode = ctrl_r[`PBC_CTRL_QUAL+1:`PBC_CTRL_QUAL];
  wire pbc_pkg::pbc_poly_e poly_sel =
    pbc_pkg::pbc_poly_e'(ctrl_r[`PBC_CTRL_POLY+2:`PBC_CTRL_POLY]);
  wire [4:0]  degree    = pbc_degree(poly_sel);
  wire        auto_inv  = (poly_sel == pbc_pkg::poly15) ||
                          (poly_sel == pbc_pkg::poly23);

  // Link edges and qualified bits.
  wire        clk_rise  = s_clk && !clk_q_r;
  wire        clk_fall  = !s_clk && clk_q_r;
  wire        bit_edge  = edge_fall ? clk_fall : clk_rise;
  wire        qual_ok   = (qual_mode == `PBC_QUAL_NONE) ||
                          ((qual_mode == `PBC_QUAL_LOW) && !s_strb) ||
                          ((qual_mode == `PBC_QUAL_HIGH) && s_strb);
  wire        bit_take  = bit_edge && qual_ok;
  wire        rx_bit    = s_data ^ pol_inv ^ auto_inv;
  wire        rst_rise  = ext_en && s_rst && !rst_q_r;
  wire        rst_fall  = ext_en && !s_rst && rst_q_r;
  wire        in_meas   = (state_r == pbc_pkg::st_fill) || (state_r == pbc_pkg::st_check);
  wire        stop_hit  = in_meas && rst_rise;

  // Fill and check steps.
  wire        fill_take = (state_r == pbc_pkg::st_fill) && bit_take && !stop_hit;
  wire        fill_last = fill_take && (fill_cnt_r == degree - 5'h01);
  wire        chk_take  = (state_r == pbc_pkg::st_check) && bit_take && !stop_hit;
  wire        err_hit   = chk_take && (rx_bit != gen_if.expected);
  wire [31:0] bit_inc   = bit_cnt_r + 32'h0000_0001;
  wire [31:0] err_inc   = err_cnt_r + 32'h0000_0001;
  wire [6:0]  win_err_n = win_err_r + {6'h00, err_hit};
  wire        win_end   = chk_take && (win_cnt_r == `PBC_WIN_LEN - 7'h01);
  wire        misalign  = win_end && (win_err_n >= `PBC_WIN_THR);
  wire        hit_bits  = chk_take && (bit_inc >= bit_lim_r);
  wire        hit_errs  = err_hit && (err_inc >= err_lim_r);
  wire        lim_hit   = (hit_bits || hit_errs) && !misalign;

  assign bit_cnt_nxt = chk_take ? bit_inc : bit_cnt_r;
  assign err_cnt_nxt = err_hit ? err_inc : err_cnt_r;

  assign gen_if.step     = fill_take || chk_take;
  assign gen_if.fill     = (state_r == pbc_pkg::st_fill);
  assign gen_if.fill_bit = rx_bit;
  assign gen_if.poly     = poly_sel;

  // Sequencing of a measurement.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pbc_pkg::st_idle:  state_nxt = state_r;
      pbc_pkg::st_fill:  if (stop_hit) state_nxt = pbc_pkg::st_pause;
                         else if (fill_last) state_nxt = pbc_pkg::st_check;
      pbc_pkg::st_check: if (stop_hit) state_nxt = pbc_pkg::st_pause;
                         else if (misalign) state_nxt = pbc_pkg::st_fill;
                         else if (lim_hit) state_nxt = pbc_pkg::st_done;
      pbc_pkg::st_pause: if (!ext_en || rst_fall) state_nxt = pbc_pkg::st_fill;
      pbc_pkg::st_done:  state_nxt = state_r;
      default:           state_nxt = pbc_pkg::st_idle;
    endcase
    if (start_wr)
      state_nxt = pbc_pkg::st_fill;
    else if (stop_wr)
      state_nxt = pbc_pkg::st_idle;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= pbc_pkg::st_idle;
      clk_q_r <= 1'b0;
      rst_q_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      clk_q_r <= s_clk;
      rst_q_r <= s_rst;
    end
  end

  // Counters, fill progress, alignment window and ending cause.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_r   <= '0;
      err_cnt_r   <= '0;
      base_bits_r <= '0;
      base_errs_r <= '0;
      by_bits_r   <= 1'b0;
      by_errs_r   <= 1'b0;
    end
    else if (start_wr)
    begin
      bit_cnt_r   <= '0;
      err_cnt_r   <= '0;
      base_bits_r <= '0;
      base_errs_r <= '0;
      by_bits_r   <= 1'b0;
      by_errs_r   <= 1'b0;
    end
    else if (misalign && !stop_hit)
    begin
      bit_cnt_r   <= base_bits_r;
      err_cnt_r   <= base_errs_r;
    end
    else
    begin
      bit_cnt_r   <= bit_cnt_nxt;
      err_cnt_r   <= err_cnt_nxt;
      if ((state_r == pbc_pkg::st_pause) && (state_nxt == pbc_pkg::st_fill))
      begin
        base_bits_r <= bit_cnt_r;
        base_errs_r <= err_cnt_r;
      end
      if (lim_hit && !stop_hit)
      begin
        by_bits_r   <= hit_bits;
        by_errs_r   <= hit_errs;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fill_cnt_r <= '0;
      win_cnt_r  <= '0;
      win_err_r  <= '0;
      sync_r     <= 1'b0;
    end
    else if (state_nxt != pbc_pkg::st_check)
    begin
      fill_cnt_r <= (fill_take && !start_wr) ? fill_cnt_r + 5'h01 :
                    ((gen_if.fill && !start_wr) ? fill_cnt_r : 5'h00);
      win_cnt_r  <= '0;
      win_err_r  <= '0;
      sync_r     <= 1'b0;
    end
    else
    begin
      fill_cnt_r <= '0;
      win_cnt_r  <= chk_take ? (win_end ? 7'h00 : win_cnt_r + 7'h01) : win_cnt_r;
      win_err_r  <= win_end ? 7'h00 : win_err_n;
      sync_r     <= 1'b1;
    end
  end

  // AHB-Lite slave: zero-wait writes, one wait state on reads, always OKAY.
  wire [31:0] status_w = {27'h0, state_r == pbc_pkg::st_done, in_meas, by_errs_r, by_bits_r,
                          sync_r};
  wire [31:0] rd_mux   = (addr_r == `PBC_OFF_CTRL)   ? {23'h0, ctrl_r} :
                         (addr_r == `PBC_OFF_BITLIM) ? bit_lim_r :
                         (addr_r == `PBC_OFF_ERRLIM) ? err_lim_r :
                         (addr_r == `PBC_OFF_STATUS) ? status_w :
                         (addr_r == `PBC_OFF_BITCNT) ? bit_cnt_r :
                         (addr_r == `PBC_OFF_ERRCNT) ? err_cnt_r : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_r <= addr_take && hwrite;
        rd_pend_r <= addr_take && !hwrite;
        hreadyout <= !(addr_take && !hwrite);
      end
      else
      begin
        rd_pend_r <= 1'b0;
        hreadyout <= 1'b1;
      end
      if (addr_take)
        addr_r <= haddr[7:0];
      if (rd_pend_r)
        hrdata <= rd_mux;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r    <= `PBC_CTRL_RST;
      bit_lim_r <= `PBC_BITLIM_RST;
      err_lim_r <= `PBC_ERRLIM_RST;
    end
    else if (bus_wr)
    begin
      if (addr_r == `PBC_OFF_CTRL)
        ctrl_r <= hwdata[8:0];
      if (addr_r == `PBC_OFF_BITLIM)
        bit_lim_r <= hwdata;
      if (addr_r == `PBC_OFF_ERRLIM)
        err_lim_r <= hwdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_meas_stop;
    in_meas && rst_rise && !ctrl_wr;
  endsequence
  sequence s_sub_start;
    state_r == pbc_pkg::st_pause && rst_fall && !ctrl_wr;
  endsequence

  a_fill_no_count: assert property (
    state_r == pbc_pkg::st_fill && !start_wr |=> $stable(err_cnt_r) && $stable(bit_cnt_r))
    else $error("Counts moved during fill.");
  a_restart_stops: assert property (
    s_meas_stop |=> state_r == pbc_pkg::st_pause ##1 $stable(bit_cnt_r))
    else $error("Restart rise did not stop the measurement.");
  a_sub_refill: assert property (
    s_sub_start |=> state_r == pbc_pkg::st_fill && !sync_r && base_bits_r == $past(bit_cnt_r))
    else $error("Restart fall did not refill.");
  a_bit_limit_end: assert property (
    chk_take && !stop_hit && !misalign && !ctrl_wr && bit_inc >= bit_lim_r
      |=> state_r == pbc_pkg::st_done && by_bits_r)
    else $error("Bit limit did not end the measurement.");
  a_err_limit_end: assert property (
    err_hit && !stop_hit && !misalign && !ctrl_wr && err_inc >= err_lim_r
      |=> state_r == pbc_pkg::st_done && by_errs_r && err_cnt_r == $past(err_inc))
    else $error("Error limit did not end the measurement.");
  a_start_clears: assert property (
    start_wr |=> bit_cnt_r == 32'h0 && err_cnt_r == 32'h0 && !by_bits_r && !by_errs_r)
    else $error("Start did not clear the results.");
  a_sync_after_fill: assert property (
    $rose(sync_r) |-> $past(fill_last) && $past(fill_cnt_r) == $past(degree) - 5'h01)
    else $error("Sync rose without a full fill.");
  a_unqual_hold: assert property (
    state_r == pbc_pkg::st_check && !bit_take && !ctrl_wr |=> $stable(bit_cnt_r))
    else $error("Count moved on an unqualified bit.");
  a_misalign_redo: assert property (
    misalign && !stop_hit && !ctrl_wr
      |=> state_r == pbc_pkg::st_fill && bit_cnt_r == $past(base_bits_r))
    else $error("Misalignment did not restart the measurement.");
endmodule : pbc_checker

/* core/pbc_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the sequence checker.
// Assumes: Byte addresses on a 32-bit bus, one register per aligned word.
// Notes: Included by bare name; definitions only.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

`define PBC_OFF_CTRL     8'h00
`define PBC_OFF_BITLIM   8'h04
`define PBC_OFF_ERRLIM   8'h08
`define PBC_OFF_STATUS   8'h0c
`define PBC_OFF_BITCNT   8'h10
`define PBC_OFF_ERRCNT   8'h14

`define PBC_CTRL_RUN     0
`define PBC_CTRL_EXTRST  1
`define PBC_CTRL_POLY    2
`define PBC_CTRL_POL     5
`define PBC_CTRL_EDGE    6
`define PBC_CTRL_QUAL    7

`define PBC_CTRL_RST     9'h000
`define PBC_BITLIM_RST   32'h0000_0400
`define PBC_ERRLIM_RST   32'h0000_0064

`define PBC_QUAL_NONE    2'h0
`define PBC_QUAL_LOW     2'h1
`define PBC_QUAL_HIGH    2'h2

`define PBC_WIN_LEN      7'h40
`define PBC_WIN_THR      7'h18

`endif

/* core/pbc_pkg.sv */
// Purpose: Types shared by the sequence checker modules.
// Assumes: Nothing beyond the standard types.
// Notes: No constants here; they live in the header.
package pbc_pkg;

  typedef enum logic [2:0] {
    poly9, poly11, poly15, poly16, poly20, poly21, poly23
  } pbc_poly_e;

  typedef enum logic [2:0] {
    st_idle, st_fill, st_check, st_pause, st_done
  } pbc_state_e;

endpackage : pbc_pkg

/* core/pbc_gen_if.sv */
// Purpose: Link between the checker control and its reference generator.
// Assumes: One clock domain.
// Notes: Expected bit is the generator feedback for the current state.
`timescale 1ns/1ps
interface pbc_gen_if;
  logic                step;
  logic                fill;
  logic                fill_bit;
  logic                expected;
  pbc_pkg::pbc_poly_e  poly;

  modport gen (input step, input fill, input fill_bit, input poly, output expected);
  modport chk (output step, output fill, output fill_bit, output poly, input expected);
endinterface : pbc_gen_if

/* core/pbc_sync.sv */
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs are levels; edges are found after the second stage.
// Notes: Only the second stage is read outside this module.
`timescale 1ns/1ps
module pbc_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r   <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : pbc_sync

/* core/pbc_lfsr.sv */
// Purpose: Reference sequence generator, filled from received bits or self-fed.
// Assumes: New bit enters at bit 0; taps follow the selected polynomial.
// Notes: State holds while step is low.
`timescale 1ns/1ps
module pbc_lfsr #(
  parameter int MAX_DEG = 23
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  pbc_gen_if.gen    gen
);
  logic [MAX_DEG-1:0] lfsr_r;
  logic [MAX_DEG-1:0] lfsr_nxt;
  logic               fb;
  logic               new_bit;

  function automatic logic pbc_feedback(input logic [MAX_DEG-1:0] s,
                                        input pbc_pkg::pbc_poly_e p);
    case (p)
      pbc_pkg::poly9:  return s[8] ^ s[3];
      pbc_pkg::poly11: return s[10] ^ s[1];
      pbc_pkg::poly15: return s[14] ^ s[0];
      pbc_pkg::poly16: return s[15] ^ s[4] ^ s[2] ^ s[1];
      pbc_pkg::poly20: return s[19] ^ s[2];
      pbc_pkg::poly21: return s[20] ^ s[1];
      pbc_pkg::poly23: return s[22] ^ s[4];
      default:         return s[8] ^ s[3];
    endcase
  endfunction : pbc_feedback

  assign fb           = pbc_feedback(lfsr_r, gen.poly);
  assign gen.expected = fb;
  assign new_bit      = gen.fill ? gen.fill_bit : fb;
  assign lfsr_nxt     = {lfsr_r[MAX_DEG-2:0], new_bit};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      lfsr_r <= '0;
    else if (gen.step)
      lfsr_r <= lfsr_nxt;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_lfsr_self_feed: assert property (
    gen.step && !gen.fill |=> lfsr_r[0] == $past(fb))
    else $error("Generator did not take its own feedback.");
  a_lfsr_fill_load: assert property (
    gen.step && gen.fill |=> lfsr_r[0] == $past(gen.fill_bit) && lfsr_r[1] == $past(lfsr_r[0]))
    else $error("Generator did not load the received bit.");
  a_lfsr_hold_idle: assert property (
    !gen.step |=> $stable(lfsr_r))
    else $error("Generator moved without a step.");
endmodule : pbc_lfsr

/* testbench/pbc_src_model.sv */
// Purpose: Far-end source returning sequence bits, link clock, strobe and restart.
// Assumes: Bit period 160 ns; data change half a period before the sampling edge.
// Notes: Link clock stands still while idle or paused; data then keep changing.
`timescale 1ns/1ps
module pbc_src_model (
  input  wire logic               en,
  input  wire pbc_pkg::pbc_poly_e poly,
  input  wire logic               fall,
  input  wire logic               strobe_low,
  input  wire logic               gap,
  input  wire logic               err_fill,
  input  wire logic               err_every4,
  input  wire logic [7:0]         seq_len,
  input  wire logic               data_inv,
  output logic                    link_clk,
  output logic                    link_data,
  output logic                    data_qualify_strobe,
  output logic                    restart_input
);
  int          deg [7] = '{9, 11, 15, 16, 20, 21, 23};
  int          tap [7] = '{4, 2, 1, 5, 3, 2, 5};
  logic [22:0] st;
  logic        fb;
  logic        inv;
  int          n;
  int          k;
  int          c;

  task automatic idle(input int cnt);
    repeat (cnt)
    begin
      link_data = ~link_data;
      #80;
    end
  endtask : idle

  task automatic pulse();
    restart_input = 1'b1;   // Marker at each end of the stored block.
    idle(8);
    restart_input = 1'b0;
    idle(4);
  endtask : pulse

  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b0;
    data_qualify_strobe = 1'b0;
    restart_input = 1'b0;
    forever
    begin
      while (!en) idle(1);
      st = 23'h7f_ffff;
      k = 0;
      c = 0;
      n = deg[int'(poly)];
      inv = (n == 15 || n == 23);
      while (en)
      begin
        if (seq_len != 8'h00 && k == int'(seq_len))
        begin
          pulse();
          st = 23'h7f_ffff;
          k = 0;
        end
        if (seq_len != 8'h00 && k == 0) pulse();
        fb = (n == 16) ? (st[15] ^ st[4] ^ st[2] ^ st[1]) : (st[n-1] ^ st[tap[int'(poly)]-1]);
        c++;
        link_clk = fall;
        if (gap && c % 3 == 0)
        begin
          data_qualify_strobe = strobe_low;   // Unqualified slot carries a wrong bit.
          link_data = ~(fb ^ inv ^ data_inv);
        end
        else
        begin
          data_qualify_strobe = ~strobe_low;
          link_data = fb ^ inv ^ data_inv ^ ((err_fill && k == 0) ||
                      (err_every4 && k >= n && (k - n) % 4 == 3));
          st = {st[21:0], fb};
          k++;
        end
        #80;
        link_clk = ~fall;
        #80;
      end
      link_clk = 1'b0;
    end
  end
endmodule : pbc_src_model

/* testbench/pbc_checker_tb.sv */
// Purpose: Self-checking bench for the sequence error checker.
// Assumes: One slave on the bus; hready is its own hreadyout.
// Notes: Tests are sequences of register calls with expected values.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_checker_tb;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic               core_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic               link_clk;
  logic               link_data;
  logic               data_qualify_strobe;
  logic               restart_input;
  logic               m_en = 1'b0;
  logic               m_fall = 1'b0;
  logic               m_low = 1'b0;
  logic               m_gap = 1'b0;
  logic               m_efill = 1'b0;
  logic               m_e4 = 1'b0;
  logic               m_inv = 1'b0;
  logic [7:0]         m_seq = 8'h00;
  pbc_pkg::pbc_poly_e m_poly = pbc_pkg::poly9;
  logic [31:0]        rd;
  logic [7:0]         offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0]        rstv [6] = '{32'h0, `PBC_BITLIM_RST, `PBC_ERRLIM_RST, 32'h0, 32'h0, 32'h0};
  int                 bad_count = 0;
  int                 cmp_count = 0;
  int                 p;

  always #10 core_clk = ~core_clk;

  pbc_checker i_pbc_checker (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link_clk, .link_data,
    .data_qualify_strobe, .restart_input);
  pbc_src_model i_pbc_src_model (.en(m_en), .poly(m_poly), .fall(m_fall), .strobe_low(m_low),
    .gap(m_gap), .err_fill(m_efill), .err_every4(m_e4), .seq_len(m_seq), .data_inv(m_inv),
    .link_clk, .link_data, .data_qualify_strobe, .restart_input);

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : cmp

  task automatic wait_ready();
    int t;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (hreadyout !== 1'b1 && t < 40);
    if (hreadyout !== 1'b1)
    begin
      cmp("hreadyout", 32'h1, {31'h0, hreadyout});
      tally_and_finish();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, rd & m);
  endtask : chk

  task automatic run(input logic [2:0] pl, input logic [31:0] ctrl, input logic [31:0] bl,
                     input logic [31:0] el, input logic [31:0] eb, input logic [31:0] ee,
                     input logic [31:0] cause);
    int   t;
    logic synced;
    bus(1'b1, `PBC_OFF_BITLIM, bl);
    bus(1'b1, `PBC_OFF_ERRLIM, el);
    bus(1'b1, `PBC_OFF_CTRL, ctrl | {27'h0, pl, 2'h1});
    chk(`PBC_OFF_BITCNT, ALL, 32'h0, "bit count at start");
    chk(`PBC_OFF_ERRCNT, ALL, 32'h0, "error count at start");
    chk(`PBC_OFF_STATUS, ALL, 32'h8, "status at start");
    m_poly <= pbc_pkg::pbc_poly_e'(pl);
    m_en <= 1'b1;
    synced = 1'b0;
    t = 0;
    do
    begin
      bus(1'b0, `PBC_OFF_STATUS, 32'h0);
      synced = synced | (rd[0] === 1'b1);
      t++;
    end
    while (rd[4] !== 1'b1 && t < 5000);
    m_en <= 1'b0;
    cmp("done flag", 32'h1, {31'h0, rd[4]});
    if (rd[4] !== 1'b1) tally_and_finish();
    cmp("sync seen", 32'h1, {31'h0, synced});
    chk(`PBC_OFF_BITCNT, ALL, eb, "bit count");
    chk(`PBC_OFF_ERRCNT, ALL, ee, "error count");
    chk(`PBC_OFF_STATUS, 32'h16, cause | 32'h10, "ending cause");
    repeat (80) @(posedge core_clk);
    $display("Test with control %h poly %0d done", ctrl, pl);
  endtask : run

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (p = 0; p < 6; p++) chk(offs[p], ALL, rstv[p], "reset value");
    bus(1'b1, 8'h18, 32'h5a5a_5a5a);
    chk(8'h18, ALL, 32'h0, "unmapped word");
    bus(1'b1, `PBC_OFF_BITCNT, 32'h5a);
    chk(`PBC_OFF_BITCNT, ALL, 32'h0, "read-only count");
    bus(1'b1, `PBC_OFF_BITLIM, ALL);
    chk(`PBC_OFF_BITLIM, ALL, ALL, "wide limit");
    $display("Register test done");
    for (p = 0; p < 7; p++)
      run(p[2:0], 32'h0, p == 0 ? 32'd1100 : 32'd100, 32'd100, p == 0 ? 32'd1100 : 32'd100,
          32'h0, 32'h2);
    m_inv <= 1'b1;
    run(3'd2, 32'h20, 32'd100, 32'd100, 32'd100, 32'h0, 32'h2);
    m_inv <= 1'b0;
    m_e4 <= 1'b1;
    run(3'd1, 32'h0, 32'd1000, 32'd5, 32'd20, 32'd5, 32'h4);
    m_e4 <= 1'b0;
    m_efill <= 1'b1;
    run(3'd0, 32'h0, 32'd200, 32'd100, 32'd200, 32'h0, 32'h2);
    m_efill <= 1'b0;
    m_gap <= 1'b1;
    m_fall <= 1'b1;
    run(3'd3, 32'h140, 32'd150, 32'd100, 32'd150, 32'h0, 32'h2);
    m_fall <= 1'b0;
    m_low <= 1'b1;
    run(3'd3, 32'h80, 32'd150, 32'd100, 32'd150, 32'h0, 32'h2);
    m_gap <= 1'b0;
    m_low <= 1'b0;
    m_seq <= 8'd50;
    run(3'd0, 32'h2, 32'd120, 32'd100, 32'd120, 32'h0, 32'h2);
    bus(1'b1, `PBC_OFF_CTRL, 32'h0);
    chk(`PBC_OFF_STATUS, 32'h18, 32'h0, "stopped status");
    chk(`PBC_OFF_BITCNT, ALL, 32'd120, "count kept after stop");
    $display("Stop test done");
    tally_and_finish();
  end
endmodule : pbc_checker_tb
